// File: design/dlp_pkg.sv
// Constants and types for the converter decode and lane PHY control registers
// Function
// [RULE1] Shuffle bit 0 gives thermometer MSB encoding, 1 shuffles MSB segments; resets 0.
// [RULE2] Waveform select: 00 first zone, 01 second Nyquist mixing, 10 return-to-zero.
// [RULE3] Output strength nibble: slew from bits 1:0, drive from bits 3:2; resets 0xF.
// [RULE4] Global receiver power-down powers down all eight lanes and bias; resets 1. The code forces only the eight lane_pd outputs; it has no bias control.
// [RULE5] Lane power-down bit n powers down lane PHY n; field resets to zero.
// [RULE6] Bit 1 powers down the sync request output buffer; resets 0.
// [RULE7] Recovery control 0 holds lane PHY logic in reset, 1 runs it; resets 1.
// [RULE8] Bit 5 selects half-rate recovery, needed above 6 Gbps; resets 1.
// [RULE9] Reserved bits read their reset value; writes to read-only bits are ignored.
package dlp_pkg;

  // ==========================================================
  // Serial port framing
  localparam int INSTR_BITS = 16;
  localparam int DATA_BITS = 8;
  localparam int ADDR_BITS = 15;
  localparam int RW_BIT = 15;
  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [4:0] DATA_LAST = 5'h07;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;

  // ==========================================================
  // Register offsets
  localparam logic [14:0] OFF_SEG = 15'h0151;
  localparam logic [14:0] OFF_DECODE = 15'h0152;
  localparam logic [14:0] OFF_STRENGTH = 15'h01DF;
  localparam logic [14:0] OFF_GLOBAL_PD = 15'h0200;
  localparam logic [14:0] OFF_LANE_PD = 15'h0201;
  localparam logic [14:0] OFF_MISC_PD = 15'h0203;
  localparam logic [14:0] OFF_CDR_RST = 15'h0206;
  localparam logic [14:0] OFF_CDR_MODE = 15'h0230;

  // ==========================================================
  // Register indices, reset values and writable masks
  localparam int NUM_REGS = 8;
  localparam logic [2:0] IDX_SEG = 3'h0;
  localparam logic [2:0] IDX_DECODE = 3'h1;
  localparam logic [2:0] IDX_STRENGTH = 3'h2;
  localparam logic [2:0] IDX_GLOBAL_PD = 3'h3;
  localparam logic [2:0] IDX_LANE_PD = 3'h4;
  localparam logic [2:0] IDX_MISC_PD = 3'h5;
  localparam logic [2:0] IDX_CDR_RST = 3'h6;
  localparam logic [2:0] IDX_CDR_MODE = 3'h7;
  localparam logic [7:0] REG_RESET [0:7] = '{8'h00, 8'h00, 8'h0F, 8'h01, 8'h00, 8'h00, 8'h01, 8'h20};
  localparam logic [7:0] REG_WMASK [0:7] = '{8'hFF, 8'h03, 8'h0F, 8'h01, 8'hFF, 8'h03, 8'h01, 8'hFF};
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ==========================================================
  // Field positions
  localparam int SHUFFLE_BIT = 2;
  localparam int DECODE_LSB = 0;
  localparam int SLEW_LSB = 0;
  localparam int DRIVE_LSB = 2;
  localparam int GLOBAL_PD_BIT = 0;
  localparam int SYNC_PD_BIT = 1;
  localparam int CDR_RUN_BIT = 0;
  localparam int HALF_RATE_BIT = 5;
  localparam int DIV_LSB = 1;
  localparam int NUM_LANES = 8;

  // ==========================================================
  // Waveform select codes
  typedef enum logic [1:0] {
    DLP_DEC_FIRST_ZONE = 2'h0,
    DLP_DEC_MIX = 2'h1,
    DLP_DEC_RTZ = 2'h2,
    DLP_DEC_RESERVED = 2'h3
  } dlp_decode_type;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic [14:0] addr;
    logic [7:0] wdata;
  } dlp_req_type;

  typedef struct packed {
    logic shuffle_en;
    dlp_decode_type decode_mode;
    logic [1:0] spi_slew;
    logic [1:0] spi_drive;
    logic rx_global_pd;
    logic [7:0] lane_pd_field;
    logic [7:0] lane_pd;
    logic sync_buf_pd;
    logic cdr_run;
    logic half_rate;
    logic [1:0] cdr_division;
  } dlp_ctrl_type;

endpackage

// File: design/dlp_reg_cell.sv
// One control register with a reset value and a mask of writable bits
`timescale 1ns/1ps
module dlp_reg_cell #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Write side
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  // Stored value
  output logic [7:0] q
);

  logic [7:0] q_d;

  always_comb begin
    q_d = q;
    if (wr_en) begin
      // Read-only bits keep their value whatever is written
      q_d = (wdata & WMASK) | (q & ~WMASK); // RULE9
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RESET_VAL;
    end else begin
      q <= q_d;
    end
  end

endmodule

// File: design/dlp_regs_top.sv
// Serial control port and register bank for decode and lane PHY controls
`timescale 1ns/1ps
module dlp_regs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Serial control port
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Control outputs
  output dlp_pkg::dlp_ctrl_type ctrl
);

  // ==========================================================
  // Serial engine state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA = 2'b11,
    ST_HOLD = 2'b10
  } dlp_state_type;

  dlp_state_type state_q, state_d;
  logic sclk_q;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] instr_q, instr_d;
  logic [7:0] wsh_q, wsh_d;
  logic [7:0] rsh_q, rsh_d;
  logic sdo_q, sdo_d;
  logic oe_q, oe_d;
  dlp_pkg::dlp_req_type req_q, req_d;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] src_byte;
  logic [7:0] rd_data;
  logic [3:0] rd_hit;
  logic [3:0] wr_hit;
  logic [7:0] reg_q [0:7];

  // Inputs are synchronous, so sclk edges are found by one delay stage
  assign sclk_rise = spi_sclk & ~sclk_q;
  assign sclk_fall = ~spi_sclk & sclk_q;

  // ==========================================================
  // Address decode
  function automatic logic [3:0] reg_lookup(input logic [14:0] a);
    if (a == dlp_pkg::OFF_SEG) begin
      return {1'b1, dlp_pkg::IDX_SEG};
    end else if (a == dlp_pkg::OFF_DECODE) begin
      return {1'b1, dlp_pkg::IDX_DECODE};
    end else if (a == dlp_pkg::OFF_STRENGTH) begin
      return {1'b1, dlp_pkg::IDX_STRENGTH};
    end else if (a == dlp_pkg::OFF_GLOBAL_PD) begin
      return {1'b1, dlp_pkg::IDX_GLOBAL_PD};
    end else if (a == dlp_pkg::OFF_LANE_PD) begin
      return {1'b1, dlp_pkg::IDX_LANE_PD};
    end else if (a == dlp_pkg::OFF_MISC_PD) begin
      return {1'b1, dlp_pkg::IDX_MISC_PD};
    end else if (a == dlp_pkg::OFF_CDR_RST) begin
      return {1'b1, dlp_pkg::IDX_CDR_RST};
    end else if (a == dlp_pkg::OFF_CDR_MODE) begin
      return {1'b1, dlp_pkg::IDX_CDR_MODE};
    end else begin
      return 4'h0;
    end
  endfunction

  assign rd_hit = reg_lookup(instr_q[dlp_pkg::ADDR_BITS-1:0]);
  assign wr_hit = reg_lookup(req_q.addr);
  // Unmapped addresses read as zero and ignore writes
  assign rd_data = rd_hit[3] ? reg_q[rd_hit[2:0]] : dlp_pkg::UNMAPPED_DATA; // RULE9

  // ==========================================================
  // Serial engine: 16-bit instruction, read flag first, then one byte
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    instr_d = instr_q;
    wsh_d = wsh_q;
    rsh_d = rsh_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    req_d = '0;
    req_d.addr = instr_q[dlp_pkg::ADDR_BITS-1:0];
    req_d.wdata = {wsh_q[6:0], spi_sdi};
    src_byte = (cnt_q == dlp_pkg::CNT_ZERO) ? rd_data : rsh_q;
    if (spi_cs_n) begin
      state_d = ST_IDLE;
      cnt_d = dlp_pkg::CNT_ZERO;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_INSTR;
          cnt_d = dlp_pkg::CNT_ZERO;
        end
        ST_INSTR: begin
          if (sclk_rise) begin
            instr_d = {instr_q[14:0], spi_sdi};
            if (cnt_q == dlp_pkg::INSTR_LAST) begin
              state_d = ST_DATA;
              cnt_d = dlp_pkg::CNT_ZERO;
              oe_d = instr_q[dlp_pkg::RW_BIT-1];
            end else begin
              cnt_d = cnt_q + dlp_pkg::CNT_ONE;
            end
          end
        end
        ST_DATA: begin
          // Read data leaves on falling edges so the master samples on rising ones
          if (sclk_fall && instr_q[dlp_pkg::RW_BIT]) begin
            sdo_d = src_byte[7];
            rsh_d = {src_byte[6:0], 1'b0};
          end
          if (sclk_rise) begin
            wsh_d = {wsh_q[6:0], spi_sdi};
            if (cnt_q == dlp_pkg::DATA_LAST) begin
              state_d = ST_HOLD;
              req_d.wr = ~instr_q[dlp_pkg::RW_BIT];
            end else begin
              cnt_d = cnt_q + dlp_pkg::CNT_ONE;
            end
          end
        end
        ST_HOLD: begin
          // Extra clocks are ignored until chip select rises
          state_d = ST_HOLD;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      sclk_q <= 1'b0;
      cnt_q <= dlp_pkg::CNT_ZERO;
      instr_q <= 16'h0000;
      wsh_q <= 8'h00;
      rsh_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      req_q <= '0;
    end else begin
      state_q <= state_d;
      sclk_q <= spi_sclk;
      cnt_q <= cnt_d;
      instr_q <= instr_d;
      wsh_q <= wsh_d;
      rsh_q <= rsh_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      req_q <= req_d;
    end
  end

  assign spi_sdo = sdo_q;
  assign spi_sdo_oe = oe_q;

  // ==========================================================
  // Register bank
  genvar g;
  generate
    for (g = 0; g < dlp_pkg::NUM_REGS; g++) begin : gen_reg
      dlp_reg_cell #(
        .RESET_VAL(dlp_pkg::REG_RESET[g]),
        .WMASK(dlp_pkg::REG_WMASK[g])
      ) u_cell (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(req_q.wr && wr_hit[3] && (wr_hit[2:0] == 3'(g))),
        .wdata(req_q.wdata),
        .q(reg_q[g])
      );
    end
  endgenerate

  // ==========================================================
  // Control fields
  assign ctrl.shuffle_en = reg_q[dlp_pkg::IDX_SEG][dlp_pkg::SHUFFLE_BIT]; // RULE1
  // Code 11 is passed through unchanged; the analog side treats it as reserved
  assign ctrl.decode_mode = dlp_pkg::dlp_decode_type'(reg_q[dlp_pkg::IDX_DECODE][dlp_pkg::DECODE_LSB +: 2]); // RULE2
  assign ctrl.spi_slew = reg_q[dlp_pkg::IDX_STRENGTH][dlp_pkg::SLEW_LSB +: 2]; // RULE3
  assign ctrl.spi_drive = reg_q[dlp_pkg::IDX_STRENGTH][dlp_pkg::DRIVE_LSB +: 2]; // RULE3
  assign ctrl.rx_global_pd = reg_q[dlp_pkg::IDX_GLOBAL_PD][dlp_pkg::GLOBAL_PD_BIT]; // RULE4
  assign ctrl.lane_pd_field = reg_q[dlp_pkg::IDX_LANE_PD];
  generate
    for (g = 0; g < dlp_pkg::NUM_LANES; g++) begin : gen_lane
      // The global power-down dominates each lane override
      assign ctrl.lane_pd[g] = reg_q[dlp_pkg::IDX_LANE_PD][g] | ctrl.rx_global_pd; // RULE4 RULE5
    end
  endgenerate
  assign ctrl.sync_buf_pd = reg_q[dlp_pkg::IDX_MISC_PD][dlp_pkg::SYNC_PD_BIT]; // RULE6
  assign ctrl.cdr_run = reg_q[dlp_pkg::IDX_CDR_RST][dlp_pkg::CDR_RUN_BIT]; // RULE7
  assign ctrl.half_rate = reg_q[dlp_pkg::IDX_CDR_MODE][dlp_pkg::HALF_RATE_BIT]; // RULE8
  assign ctrl.cdr_division = reg_q[dlp_pkg::IDX_CDR_MODE][dlp_pkg::DIV_LSB +: 2];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_reg_write(logic [14:0] off);
    req_q.wr && req_q.addr == off;
  endsequence

  sequence s_last_write_bit;
    state_q == ST_DATA && sclk_rise && cnt_q == dlp_pkg::DATA_LAST && !instr_q[dlp_pkg::RW_BIT];
  endsequence

  chk_shuffle_write: assert property ( // RULE1
    s_reg_write(dlp_pkg::OFF_SEG) |=> ctrl.shuffle_en == $past(req_q.wdata[dlp_pkg::SHUFFLE_BIT]))
    else $error("shuffle control did not follow write");

  chk_decode_write: assert property ( // RULE2
    s_reg_write(dlp_pkg::OFF_DECODE) |=> ctrl.decode_mode == $past(req_q.wdata[1:0]))
    else $error("waveform select did not follow write");

  chk_strength_split: assert property ( // RULE3
    s_reg_write(dlp_pkg::OFF_STRENGTH) |=>
      ctrl.spi_slew == $past(req_q.wdata[1:0]) && ctrl.spi_drive == $past(req_q.wdata[3:2]))
    else $error("slew or drive field mismatch");

  chk_global_pd_lanes: assert property ( // RULE4
    ctrl.rx_global_pd |-> ctrl.lane_pd == 8'hFF)
    else $error("global power-down left a lane powered");

  chk_lane_pd_map: assert property ( // RULE5
    s_reg_write(dlp_pkg::OFF_LANE_PD) |=>
      ctrl.lane_pd_field == $past(req_q.wdata) && (ctrl.rx_global_pd || ctrl.lane_pd == $past(req_q.wdata)))
    else $error("lane power-down mapping mismatch");

  chk_sync_pd_write: assert property ( // RULE6
    s_reg_write(dlp_pkg::OFF_MISC_PD) |=> ctrl.sync_buf_pd == $past(req_q.wdata[dlp_pkg::SYNC_PD_BIT]))
    else $error("sync buffer power-down mismatch");

  chk_cdr_run_write: assert property ( // RULE7
    s_reg_write(dlp_pkg::OFF_CDR_RST) |=> ctrl.cdr_run == $past(req_q.wdata[dlp_pkg::CDR_RUN_BIT]))
    else $error("recovery reset control mismatch");

  chk_half_rate_write: assert property ( // RULE8
    s_reg_write(dlp_pkg::OFF_CDR_MODE) |=> ctrl.half_rate == $past(req_q.wdata[dlp_pkg::HALF_RATE_BIT]))
    else $error("half-rate enable mismatch");

  chk_reserved_fixed: assert property ( // RULE9
    s_reg_write(dlp_pkg::OFF_DECODE) |=>
      (reg_q[dlp_pkg::IDX_DECODE] & ~dlp_pkg::REG_WMASK[dlp_pkg::IDX_DECODE]) ==
      (dlp_pkg::REG_RESET[dlp_pkg::IDX_DECODE] & ~dlp_pkg::REG_WMASK[dlp_pkg::IDX_DECODE]))
    else $error("read-only reserved bits changed");

  chk_serial_write_path: assert property (
    s_last_write_bit ##1 1'b1 |-> req_q.wr ##1 !req_q.wr)
    else $error("serial write did not issue one strobe");

endmodule

// File: bench/dlp_regs_top_tb_top.sv
// Self-checking testbench for the decode and lane PHY control register bank
`timescale 1ns/1ps
module dlp_regs_top_tb_top;
  // ==========================================================
  // Signals
  logic clk;
  logic arst_n;
  logic spi_cs_n;
  logic spi_sclk;
  logic spi_sdi;
  logic spi_sdo;
  logic spi_sdo_oe;
  dlp_pkg::dlp_ctrl_type ctrl;
  dlp_pkg::dlp_ctrl_type exp_ctrl;
  int fails;
  int tests_run;
  logic [7:0] rdat;
  logic [14:0] offs [0:7];
  logic [7:0] rst_exp [0:7];
  logic [7:0] ones_exp [0:7];

  dlp_regs_top u_dut (
    .clk(clk),
    .arst_n(arst_n),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .ctrl(ctrl)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Serial frame: four clocks per sclk phase keeps well above the two-clock minimum
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, input int nbits,
                      output logic [7:0] rd_out);
    logic [23:0] f;
    f = {rd, a, wd};
    rd_out = 8'h00;
    @(negedge clk);
    spi_cs_n = 1'b0;
    repeat (2) @(negedge clk);
    for (int i = 0; i < nbits; i++) begin
      spi_sclk = 1'b0;
      spi_sdi = f[23-i];
      repeat (4) @(negedge clk);
      if (rd && i >= 16) begin
        rd_out = {rd_out[6:0], spi_sdo};
        chk(spi_sdo_oe, 1'b1, "sdo enable in read data");
      end
      spi_sclk = 1'b1;
      repeat (4) @(negedge clk);
    end
    spi_sclk = 1'b0;
    repeat (4) @(negedge clk);
    spi_cs_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    xfer(1'b0, a, d, 24, dummy);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] v;
    xfer(1'b1, a, 8'h00, 24, v);
    chk(v, exp, "register read");
  endtask

  // ==========================================================
  // Watchdog
  // About 55 frames of roughly 205 clocks each, with twofold margin
  initial begin
    repeat (25000) @(posedge clk);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
    fails = 0;
    tests_run = 0;
    offs = '{dlp_pkg::OFF_SEG, dlp_pkg::OFF_DECODE, dlp_pkg::OFF_STRENGTH, dlp_pkg::OFF_GLOBAL_PD,
             dlp_pkg::OFF_LANE_PD, dlp_pkg::OFF_MISC_PD, dlp_pkg::OFF_CDR_RST, dlp_pkg::OFF_CDR_MODE};
    rst_exp = '{8'h00, 8'h00, 8'h0F, 8'h01, 8'h00, 8'h00, 8'h01, 8'h20};
    ones_exp = '{8'hFF, 8'h03, 8'h0F, 8'h01, 8'hFF, 8'h03, 8'h01, 8'hFF};
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    // Reset state of every control
    exp_ctrl = '0;
    exp_ctrl.spi_slew = 2'h3;
    exp_ctrl.spi_drive = 2'h3;
    exp_ctrl.rx_global_pd = 1'b1;
    exp_ctrl.lane_pd = 8'hFF;
    exp_ctrl.cdr_run = 1'b1;
    exp_ctrl.half_rate = 1'b1;
    chk(ctrl, exp_ctrl, "reset controls");
    chk(spi_sdo_oe, 1'b0, "sdo enable idle");
    for (int i = 0; i < 8; i++) begin
      rd_chk(offs[i], rst_exp[i]);
    end
    // All ones: read-only bits must stay at zero
    for (int i = 0; i < 8; i++) begin
      wr(offs[i], 8'hFF);
    end
    for (int i = 0; i < 8; i++) begin
      rd_chk(offs[i], ones_exp[i]);
    end
    chk(ctrl, {$bits(ctrl){1'b1}}, "all controls set");
    for (int i = 0; i < 8; i++) begin
      wr(offs[i], 8'h00);
    end
    chk(ctrl, '0, "all controls clear");
    // Every waveform code, including the reserved one
    for (int c = 0; c < 4; c++) begin
      wr(dlp_pkg::OFF_DECODE, 8'(c));
      chk(ctrl.decode_mode, c[1:0], "decode mode");
    end
    // Slew and drive taken from separate halves of the nibble
    wr(dlp_pkg::OFF_STRENGTH, 8'h06);
    chk({ctrl.spi_drive, ctrl.spi_slew}, 4'h6, "strength split");
    // Walking lane power-down with the receiver up, then global power-down
    for (int n = 0; n < 8; n++) begin
      wr(dlp_pkg::OFF_LANE_PD, 8'h01 << n);
      chk(ctrl.lane_pd, 8'h01 << n, "lane power-down");
    end
    wr(dlp_pkg::OFF_GLOBAL_PD, 8'h01);
    chk(ctrl.lane_pd, 8'hFF, "global power-down lanes");
    chk(ctrl.lane_pd_field, 8'h80, "lane field kept");
    // Only bit 1 of the misc register reaches the sync buffer
    wr(dlp_pkg::OFF_MISC_PD, 8'h01);
    chk(ctrl.sync_buf_pd, 1'b0, "sync buffer bit 0");
    wr(dlp_pkg::OFF_MISC_PD, 8'h02);
    chk(ctrl.sync_buf_pd, 1'b1, "sync buffer bit 1");
    // Shuffle bit alone, then half-rate alone
    wr(dlp_pkg::OFF_SEG, 8'h04);
    chk(ctrl.shuffle_en, 1'b1, "shuffle enable");
    wr(dlp_pkg::OFF_CDR_MODE, 8'h20);
    chk({ctrl.half_rate, ctrl.cdr_division}, 3'h4, "half rate");
    wr(dlp_pkg::OFF_CDR_RST, 8'h01);
    chk(ctrl.cdr_run, 1'b1, "recovery run");
    // Aborted frame must not write
    xfer(1'b0, dlp_pkg::OFF_SEG, 8'h00, 20, rdat);
    chk(ctrl.shuffle_en, 1'b1, "aborted write ignored");
    // Unmapped address: write ignored, read gives zero
    wr(15'h0150, 8'hA5);
    rd_chk(15'h0150, 8'h00);
    rd_chk(dlp_pkg::OFF_SEG, 8'h04);
    chk(spi_sdo_oe, 1'b0, "sdo enable released");
    close_out();
  end
endmodule
